// ===== hw/fisr_pkg.sv
// Purpose: Constants for the fault interrupt and status register block.
// Assumes: Byte-wide registers reached over an internal register port.
// Notes: Offsets are byte addresses of the management register map.
package fisr_pkg;
    localparam logic [7:0] PRIMARY_OFS = 8'h10;
    localparam logic [7:0] INTERNAL_OFS = 8'h11;
    localparam logic [7:0] VENDOR_OFS = 8'h12;
    localparam logic [7:0] PINSTATE_OFS = 8'h13;
    localparam logic [7:0] ADDRREAD_OFS = 8'hf9;
    localparam logic [7:0] HOSTCFG_OFS = 8'hfa;
    localparam logic [7:0] SOURCE_RESET = 8'h00;
    localparam logic [7:0] PINSTATE_RESET = 8'h00;
    localparam logic [31:0] ALARM_DISABLED = 32'hffffffff;
    localparam int INTERNAL_OR_BIT = 7;
    localparam int VENDOR_OR_BIT = 7;
    localparam int INT_PIN_BIT = 5;
    localparam int RST_PIN_BIT = 4;
    localparam int SLEEP_BIT = 3;
    localparam int ACTIVE_BIT = 2;
    localparam logic [1:0] WDT_OFF = 2'h0;
    localparam logic [1:0] SEQ_INVALID = 2'h2;
endpackage

// ===== hw/fisr_flag_bit.sv
// Purpose: One sticky write-one-to-clear fault flag.
// Assumes: Set and clear are single-cycle strobes.
// Notes: A clear is refused while the hold condition persists.
`timescale 1ns/100ps
module fisr_flag_bit (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // Control
    input wire logic setEvent,
    input wire logic clearReq,
    input wire logic holdActive,
    // Result
    output logic flag
);
    logic flag_next;

    // Set beats clear so an event in the clearing cycle is kept.
    assign flag_next = setEvent | (flag & ~(clearReq & ~holdActive));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag <= 1'b0;
        end else if (clkEn) begin
            flag <= flag_next;
        end
    end
endmodule

// ===== hw/fisr_regs.sv
// Purpose: Interrupt source and pin status registers of the sequencer.
// Assumes: Event inputs are single-cycle pulses synchronous to clk.
// Notes: Fault conditions are levels; a flag stays while its level holds.
`timescale 1ns/100ps
module fisr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Event pulses
    input wire logic emergencyPowerdownEvt,
    input wire logic watchdogViolationEvt,
    input wire logic packetMiscompareEvt,
    input wire logic alarmEvt,
    input wire logic runtimeCrcEvt,
    input wire logic selftestFaultEvt,
    input wire logic doubleErrorEvt,
    input wire logic buttonShortPulseEvt,
    input wire logic [7:0] vendorFaultEvt,
    // Fault condition levels
    input wire logic enableShortFault,
    input wire logic crystalFault,
    input wire logic outputPinLeakFault,
    input wire logic regulatorFault,
    input wire logic thermalFault,
    // Configuration from elsewhere
    input wire logic [1:0] watchdogEnableField,
    input wire logic packetCheckEnable,
    input wire logic alarmWakeEnable,
    input wire logic alarmPowerupEnable,
    input wire logic [31:0] alarmValue,
    input wire logic crystalEnable,
    input wire logic buttonFunctionEnable,
    input wire logic [6:0] storedBusAddress,
    input wire logic [1:0] hostInterfaceConfig,
    // Pins and state
    input wire logic resetOutActive,
    input wire logic sleepIn_n,
    input wire logic activeIn,
    input wire logic [1:0] sequencerStateCode,
    output logic interrupt_out_n
);
    // ****************************************
    // Decode
    // ****************************************
    logic wrPrimary, wrInternal, wrVendor;
    logic [7:0] primarySource, internalSource, vendorFault;
    logic alarmDisabled;
    logic [7:0] primarySet, internalSet, primaryHold, internalHold;
    logic [7:0] pinState;
    logic [7:0] readMux;
    logic [7:0] pinState_reg;
    logic interrupt_out_n_reg;

    assign wrPrimary = regWrite & (regAddr == fisr_pkg::PRIMARY_OFS);
    assign wrInternal = regWrite & (regAddr == fisr_pkg::INTERNAL_OFS);
    assign wrVendor = regWrite & (regAddr == fisr_pkg::VENDOR_OFS);

    assign alarmDisabled = ~alarmWakeEnable & ~alarmPowerupEnable &
        (alarmValue == fisr_pkg::ALARM_DISABLED);

    // ****************************************
    // Set events
    // ****************************************
    assign primarySet[7] = 1'b0;
    assign primarySet[6] = emergencyPowerdownEvt;
    assign primarySet[5] = watchdogViolationEvt &
        (watchdogEnableField != fisr_pkg::WDT_OFF);
    assign primarySet[4] = packetMiscompareEvt & packetCheckEnable;
    assign primarySet[3] = alarmEvt & ~alarmDisabled;
    assign primarySet[2] = enableShortFault;
    assign primarySet[1] = crystalFault & crystalEnable;
    assign primarySet[0] = outputPinLeakFault;
    assign primaryHold = {5'h00, primarySet[2:0]};

    assign internalSet[7] = 1'b0;
    assign internalSet[6] = 1'b0;
    assign internalSet[5] = runtimeCrcEvt;
    assign internalSet[4] = selftestFaultEvt;
    assign internalSet[3] = regulatorFault;
    assign internalSet[2] = thermalFault;
    assign internalSet[1] = doubleErrorEvt;
    assign internalSet[0] = buttonShortPulseEvt & buttonFunctionEnable;
    assign internalHold = {4'h0, internalSet[3:2], 2'h0};

    // ****************************************
    // Flags
    // ****************************************
    // Bit 7 of the primary and internal source registers is derived, so only 0..6 are stored there.
    fisr_flag_bit uPrim0 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(primarySet[0]),
        .clearReq(wrPrimary & regWrData[0]),
        .holdActive(primaryHold[0]),
        .flag(primarySource[0])
    );

    fisr_flag_bit uPrim1 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(primarySet[1]),
        .clearReq(wrPrimary & regWrData[1]),
        .holdActive(primaryHold[1]),
        .flag(primarySource[1])
    );

    fisr_flag_bit uPrim2 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(primarySet[2]),
        .clearReq(wrPrimary & regWrData[2]),
        .holdActive(primaryHold[2]),
        .flag(primarySource[2])
    );

    fisr_flag_bit uPrim3 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(primarySet[3]),
        .clearReq(wrPrimary & regWrData[3]),
        .holdActive(primaryHold[3]),
        .flag(primarySource[3])
    );

    fisr_flag_bit uPrim4 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(primarySet[4]),
        .clearReq(wrPrimary & regWrData[4]),
        .holdActive(primaryHold[4]),
        .flag(primarySource[4])
    );

    fisr_flag_bit uPrim5 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(primarySet[5]),
        .clearReq(wrPrimary & regWrData[5]),
        .holdActive(primaryHold[5]),
        .flag(primarySource[5])
    );

    fisr_flag_bit uPrim6 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(primarySet[6]),
        .clearReq(wrPrimary & regWrData[6]),
        .holdActive(primaryHold[6]),
        .flag(primarySource[6])
    );

    fisr_flag_bit uInt0 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(internalSet[0]),
        .clearReq(wrInternal & regWrData[0]),
        .holdActive(internalHold[0]),
        .flag(internalSource[0])
    );

    fisr_flag_bit uInt1 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(internalSet[1]),
        .clearReq(wrInternal & regWrData[1]),
        .holdActive(internalHold[1]),
        .flag(internalSource[1])
    );

    fisr_flag_bit uInt2 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(internalSet[2]),
        .clearReq(wrInternal & regWrData[2]),
        .holdActive(internalHold[2]),
        .flag(internalSource[2])
    );

    fisr_flag_bit uInt3 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(internalSet[3]),
        .clearReq(wrInternal & regWrData[3]),
        .holdActive(internalHold[3]),
        .flag(internalSource[3])
    );

    fisr_flag_bit uInt4 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(internalSet[4]),
        .clearReq(wrInternal & regWrData[4]),
        .holdActive(internalHold[4]),
        .flag(internalSource[4])
    );

    fisr_flag_bit uInt5 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(internalSet[5]),
        .clearReq(wrInternal & regWrData[5]),
        .holdActive(internalHold[5]),
        .flag(internalSource[5])
    );

    fisr_flag_bit uInt6 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(internalSet[6]),
        .clearReq(wrInternal & regWrData[6]),
        .holdActive(internalHold[6]),
        .flag(internalSource[6])
    );

    fisr_flag_bit uVend0 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[0]),
        .clearReq(wrVendor & regWrData[0]),
        .holdActive(1'b0),
        .flag(vendorFault[0])
    );

    fisr_flag_bit uVend1 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[1]),
        .clearReq(wrVendor & regWrData[1]),
        .holdActive(1'b0),
        .flag(vendorFault[1])
    );

    fisr_flag_bit uVend2 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[2]),
        .clearReq(wrVendor & regWrData[2]),
        .holdActive(1'b0),
        .flag(vendorFault[2])
    );

    fisr_flag_bit uVend3 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[3]),
        .clearReq(wrVendor & regWrData[3]),
        .holdActive(1'b0),
        .flag(vendorFault[3])
    );

    fisr_flag_bit uVend4 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[4]),
        .clearReq(wrVendor & regWrData[4]),
        .holdActive(1'b0),
        .flag(vendorFault[4])
    );

    fisr_flag_bit uVend5 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[5]),
        .clearReq(wrVendor & regWrData[5]),
        .holdActive(1'b0),
        .flag(vendorFault[5])
    );

    fisr_flag_bit uVend6 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[6]),
        .clearReq(wrVendor & regWrData[6]),
        .holdActive(1'b0),
        .flag(vendorFault[6])
    );

    fisr_flag_bit uVend7 (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .setEvent(vendorFaultEvt[7]),
        .clearReq(wrVendor & regWrData[7]),
        .holdActive(1'b0),
        .flag(vendorFault[7])
    );

    // The reserved secondary bit 6 never sets, so its flop folds away.
    assign internalSource[fisr_pkg::VENDOR_OR_BIT] = |vendorFault;
    assign primarySource[fisr_pkg::INTERNAL_OR_BIT] =
        |internalSource;

    // ****************************************
    // Status and read path
    // ****************************************
    assign pinState = {2'h0, interrupt_out_n_reg, ~resetOutActive,
        sleepIn_n, activeIn, sequencerStateCode};

    always_comb begin
        unique case (regAddr)
            fisr_pkg::PRIMARY_OFS: readMux = primarySource;
            fisr_pkg::INTERNAL_OFS: readMux = internalSource;
            fisr_pkg::VENDOR_OFS: readMux = vendorFault;
            fisr_pkg::PINSTATE_OFS: readMux = pinState_reg;
            fisr_pkg::ADDRREAD_OFS: readMux = {1'b0, storedBusAddress};
            fisr_pkg::HOSTCFG_OFS: readMux = {6'h00, hostInterfaceConfig};
            default: readMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            interrupt_out_n_reg <= 1'b1;
            pinState_reg <= fisr_pkg::PINSTATE_RESET;
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end else if (clkEn) begin
            interrupt_out_n_reg <= ~(|primarySource);
            pinState_reg <= pinState;
            regRdData <= regRead ? readMux : 8'h00;
            regRdValid <= regRead;
        end
    end

    assign interrupt_out_n = interrupt_out_n_reg;
endmodule

// ===== tb/fisr_props.sv
// Purpose: Port checker of the interrupt source block.
// Assumes: clkEn stays high; pins settle well before status reads.
// Notes: Status reads show pin levels two edges old.
`timescale 1ns/100ps
module fisr_props (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // Register port
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    // Interrupt and events
    input wire logic interrupt_out_n,
    input wire logic emergencyPowerdownEvt,
    // Pins and state
    input wire logic resetOutActive,
    input wire logic sleepIn_n,
    input wire logic activeIn,
    input wire logic [1:0] sequencerStateCode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_rst; disable iff (1'b0) reset |-> interrupt_out_n; endproperty
    a_rst: assert property (p_rst) else $error("irq during reset");
    property p_rdv; regRdValid == ($past(regRead) && $past(clkEn)); endproperty
    a_rdv: assert property (p_rdv) else $error("read answer late");
    property p_zero; !regRdValid |-> regRdData == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("stray read data");
    property p_irq; regRdValid && $past(regAddr) == 8'h10 |->
        interrupt_out_n == (regRdData == 8'h00); endproperty
    a_irq: assert property (p_irq) else $error("irq vs cause");
    property p_evt; emergencyPowerdownEvt && clkEn ##1 clkEn |=>
        !interrupt_out_n; endproperty
    a_evt: assert property (p_evt) else $error("event lost");
    property p_slp; regRdValid && $past(regAddr) == 8'h13 |->
        regRdData[3] == $past(sleepIn_n, 2); endproperty
    a_slp: assert property (p_slp) else $error("sleep level");
    property p_seq; regRdValid && $past(regAddr) == 8'h13 |->
        regRdData[1:0] == $past(sequencerStateCode, 2); endproperty
    a_seq: assert property (p_seq) else $error("state code");
    property p_rpin; regRdValid && $past(regAddr) == 8'h13 |->
        regRdData[4] == !$past(resetOutActive, 2); endproperty
    a_rpin: assert property (p_rpin) else $error("reset pin");
endmodule
bind fisr_regs fisr_props fisr_props_inst (.*);

// ===== tb/fisr_host.sv
// Purpose: Host processor model on the register port.
// Assumes: Strobes change only just after a rising edge.
// Notes: Write data is inverted once released, so stale data never helps.
`timescale 1ns/100ps
module fisr_host (
    // Clock
    input wire logic clk,
    // Register port requests
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    // Register port answer
    input wire logic [7:0] regRdData
);
    initial {regWrite, regRead, regAddr, regWrData} = 18'h00000;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {regWrite, regAddr, regWrData} <= {1'b1, a, d};
        @(posedge clk);
        {regWrite, regWrData} <= {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {regRead, regAddr} <= {1'b1, a};
        @(posedge clk);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the interrupt source block.
// Assumes: The host model owns the register port.
// Notes: The first eight event passes run with every gate closed except the alarm gate, which stays open as alarmValue is zero.
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, reset = 1'b0, regWrite, regRead, regRdValid;
    logic interrupt_out_n;
    logic [7:0] regAddr, regWrData, regRdData, got;
    logic [15:0] ev = 16'h0000;
    logic [5:0] en = 6'h00;
    logic [4:0] flt = 5'h00, pin = 5'h00;
    logic [31:0] alarmValue = 32'h00000000;
    int n_fail = 0, num_checks = 0, cycles = 0;
    logic [15:0] evExp [16] = '{16'h4000, 16'h0000, 16'h0000, 16'h0800,
        16'h8020, 16'h8010, 16'h8002, 16'h0000, 16'h4000, 16'h2000,
        16'h1000, 16'h0800, 16'h8020, 16'h8010, 16'h8002, 16'h8001};
    fisr_host fisr_host_inst (.clk(clk), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData));
    fisr_regs fisr_regs_inst (.clk(clk), .reset(reset), .clkEn(1'b1),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .interrupt_out_n(interrupt_out_n),
        .emergencyPowerdownEvt(ev[0]),
        .watchdogViolationEvt(ev[1]), .packetMiscompareEvt(ev[2]),
        .alarmEvt(ev[3]), .runtimeCrcEvt(ev[4]), .selftestFaultEvt(ev[5]),
        .doubleErrorEvt(ev[6]), .buttonShortPulseEvt(ev[7]),
        .vendorFaultEvt(ev[15:8]), .enableShortFault(flt[0]),
        .crystalFault(flt[1]), .outputPinLeakFault(flt[2]),
        .regulatorFault(flt[3]), .thermalFault(flt[4]),
        .watchdogEnableField(en[1:0]), .packetCheckEnable(en[2]),
        .alarmWakeEnable(en[3]), .alarmPowerupEnable(en[3]),
        .alarmValue(alarmValue), .crystalEnable(en[4]),
        .buttonFunctionEnable(en[5]), .storedBusAddress(7'h00),
        .hostInterfaceConfig(2'h0), .resetOutActive(pin[4]),
        .sleepIn_n(pin[3]), .activeIn(pin[2]), .sequencerStateCode(pin[1:0]));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) if (++cycles == 3000) close_out(1);
    task automatic close_out(input int hung);
        n_fail += hung;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) n_fail++;
        if (seen !== exp) $display("[FAIL] %0t %h %h", $time, seen, exp);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        fisr_host_inst.rd(a, got);
        chk(got, exp);
    endtask
    task automatic pulse(input logic [15:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 16'h0000;
    endtask
    task automatic t_events();
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            en <= (k < 8) ? 6'h00 : 6'h3d;
            pulse(16'h0001 << k[2:0]);
            fisr_host_inst.wr(8'h10, 8'h00);
            rc(8'h10, evExp[k][15:8]);
            rc(8'h11, evExp[k][7:0]);
            chk(8'(interrupt_out_n), 8'(evExp[k][15:8] == 8'h00));
            fisr_host_inst.wr(8'h11, 8'hff);
            fisr_host_inst.wr(8'h10, 8'hff);
        end
    endtask
    task automatic t_faults();
        @(posedge clk);
        flt <= 5'h1f;
        fisr_host_inst.wr(8'h11, 8'hff);
        fisr_host_inst.wr(8'h10, 8'hff);
        rc(8'h10, 8'h87);
        rc(8'h11, 8'h0c);
        @(posedge clk);
        flt <= 5'h00;
        fisr_host_inst.wr(8'h11, 8'hff);
        fisr_host_inst.wr(8'h10, 8'hff);
        rc(8'h10, 8'h00);
    endtask
    task automatic t_misc();
        pulse(16'h8100);
        @(posedge clk);
        pin <= 5'h1b;
        rc(8'h11, 8'h80);
        fisr_host_inst.wr(8'h12, 8'h01);
        rc(8'h12, 8'h80);
        rc(8'h13, 8'h0b);
        fisr_host_inst.wr(8'h12, 8'h80);
        rc(8'h10, 8'h00);
        rc(8'h20, 8'h00);
    endtask
    task automatic t_gates();
        @(posedge clk);
        en <= 6'h00;
        flt <= 5'h02;
        alarmValue <= 32'hffffffff;
        rc(8'h10, 8'h00);
        pulse(16'h0008);
        rc(8'h10, 8'h00);
        @(posedge clk);
        flt <= 5'h00;
        alarmValue <= 32'h00000000;
    endtask
    task automatic t_race();
        @(posedge clk);
        ev <= 16'h0001;
        fisr_host_inst.wr(8'h10, 8'h40);
        ev <= 16'h0000;
        rc(8'h10, 8'h40);
        fisr_host_inst.wr(8'h10, 8'h40);
        rc(8'h10, 8'h00);
    endtask
    task automatic t_reset();
        pulse(16'h0100);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rc(8'h12, 8'h00);
        chk(8'(interrupt_out_n), 8'h01);
    endtask
    initial begin
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_events();
        t_faults();
        t_gates();
        t_misc();
        t_race();
        t_reset();
        close_out(0);
    end
endmodule
